// ===== pbe_top.sv
// Power-management bridge extension, data byte and general event status.
// Assumes a single-cycle configuration request port on the host clock.
`timescale 1ns/10ps
module pbe_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  input wire logic [1:0] power_state_field_i,
  input wire logic video_port_enable_bit_f0_i,
  input wire logic video_port_enable_bit_f1_i,
  input wire logic [3:0] socket0_supply_i,
  input wire logic [3:0] socket1_supply_i,
  input wire logic socket0_vpp12_i,
  input wire logic socket1_vpp12_i,
  input wire logic [pbe_pkg::NUM_INPUTS-1:0] multi_terminal_i,
  input wire logic [15:0] event_enable_i,
  input wire logic event_route_on_i,
  output logic general_event_out_n_o,
  output logic general_event_oe_o,
  output logic secondary_clock_stop_o,
  output logic secondary_power_off_o
);
  pbe_evt_if gpi_evt ();

  pbe_input_sync #(
    .WIDTH(pbe_pkg::NUM_INPUTS)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .raw_i(multi_terminal_i),
    .evt(gpi_evt)
  );

  logic [7:0] ext_byte;
  logic [15:0] status;
  logic primed;
  logic vid0_prev;
  logic vid1_prev;
  logic [3:0] sup0_prev;
  logic [3:0] sup1_prev;
  logic vpp0_prev;
  logic vpp1_prev;
  logic ack;
  logic [31:0] rdata;
  logic evt_n;
  logic evt_oe;
  logic clk_stop;
  logic pwr_off;

  logic [15:0] next_status;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic next_ack;
  logic [31:0] next_rdata;
  logic next_evt_n;
  logic next_evt_oe;
  logic next_clk_stop;
  logic next_pwr_off;
  logic evt_sel;
  logic pm_sel;
  logic any_pending;
  logic d3hot;

  // Extension byte is a constant; no write path exists
  assign ext_byte = pbe_pkg::PM_BRIDGE_SUPPORT_EXT_VAL;

  // Event detection and status
  always_comb begin
    set_vec = '0;
    set_vec[pbe_pkg::BIT_SOCKET0_VIDEO] = primed & (video_port_enable_bit_f0_i ^ vid0_prev);
    set_vec[pbe_pkg::BIT_SOCKET1_VIDEO] = primed & (video_port_enable_bit_f1_i ^ vid1_prev);
    set_vec[pbe_pkg::BIT_SUPPLY_CHANGE] = primed & ((socket0_supply_i != sup0_prev) |
      (socket1_supply_i != sup1_prev));
    set_vec[pbe_pkg::BIT_TWELVE_VOLT] = primed & ((socket0_vpp12_i ^ vpp0_prev) |
      (socket1_vpp12_i ^ vpp1_prev));
    set_vec[pbe_pkg::NUM_INPUTS-1:0] = gpi_evt.change;
    evt_sel = cfg_req_i & (cfg_addr_i == pbe_pkg::ADDR_EVT_DWORD) & ~cfg_func_i;
    clr_vec = '0;
    if (evt_sel && cfg_we_i) begin
      clr_vec[7:0] = cfg_be_i[0] ? cfg_wdata_i[7:0] : 8'h00;
      clr_vec[15:8] = cfg_be_i[1] ? cfg_wdata_i[15:8] : 8'h00;
    end
    // Enables play no part in setting; set wins over clear
    next_status = ((status & ~clr_vec) | set_vec) & pbe_pkg::STATUS_IMPL_MASK;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status <= pbe_pkg::STATUS_RESET;
      primed <= 1'b0;
      vid0_prev <= 1'b0;
      vid1_prev <= 1'b0;
      sup0_prev <= 4'h0;
      sup1_prev <= 4'h0;
      vpp0_prev <= 1'b0;
      vpp1_prev <= 1'b0;
    end else begin
      status <= next_status;
      primed <= 1'b1;
      vid0_prev <= video_port_enable_bit_f0_i;
      vid1_prev <= video_port_enable_bit_f1_i;
      sup0_prev <= socket0_supply_i;
      sup1_prev <= socket1_supply_i;
      vpp0_prev <= socket0_vpp12_i;
      vpp1_prev <= socket1_vpp12_i;
    end
  end

  // Configuration read path
  always_comb begin
    pm_sel = cfg_addr_i == pbe_pkg::ADDR_PM_DWORD;
    next_ack = cfg_req_i;
    next_rdata = pbe_pkg::RDATA_ZERO;
    if (cfg_req_i && !cfg_we_i) begin
      if (pm_sel) begin
        next_rdata[23:16] = ext_byte;
        next_rdata[31:24] = pbe_pkg::PM_DATA_BYTE_VAL;
      end else if (cfg_addr_i == pbe_pkg::ADDR_EVT_DWORD && !cfg_func_i) begin
        next_rdata[15:0] = status;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack <= 1'b0;
      rdata <= pbe_pkg::RDATA_ZERO;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Event output and secondary bus policy
  always_comb begin
    any_pending = |(status & event_enable_i & pbe_pkg::STATUS_IMPL_MASK);
    next_evt_oe = event_route_on_i;
    next_evt_n = ~(any_pending & event_route_on_i);
    d3hot = power_state_field_i == pbe_pkg::PSTATE_D3HOT;
    next_clk_stop = ext_byte[pbe_pkg::BIT_POLICY_ON] & d3hot & ext_byte[pbe_pkg::BIT_CLOCK_STOP];
    next_pwr_off = ext_byte[pbe_pkg::BIT_POLICY_ON] & d3hot & ~ext_byte[pbe_pkg::BIT_CLOCK_STOP];
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_n <= 1'b1;
      evt_oe <= 1'b0;
      clk_stop <= 1'b0;
      pwr_off <= 1'b0;
    end else begin
      evt_n <= next_evt_n;
      evt_oe <= next_evt_oe;
      clk_stop <= next_clk_stop;
      pwr_off <= next_pwr_off;
    end
  end

  assign cfg_ack_o = ack;
  assign cfg_rdata_o = rdata;
  assign general_event_out_n_o = evt_n;
  assign general_event_oe_o = evt_oe;
  assign secondary_clock_stop_o = clk_stop;
  assign secondary_power_off_o = pwr_off;
endmodule

// ===== pbe_pkg.sv
// Package for the power-management extension and event status registers.
// Assumes byte offsets on a dword-aligned configuration port.
package pbe_pkg;
  localparam logic [7:0] ADDR_PM_DWORD = 8'hA4;
  localparam logic [7:0] ADDR_EVT_DWORD = 8'hA8;
  localparam logic [7:0] OFS_PM_BRIDGE_SUPPORT_EXT = 8'hA6;
  localparam logic [7:0] OFS_PM_DATA_BYTE = 8'hA7;
  localparam logic [7:0] OFS_GENERAL_EVENT_STATUS = 8'hA8;
  localparam logic [7:0] PM_BRIDGE_SUPPORT_EXT_VAL = 8'hC0;
  localparam logic [7:0] PM_DATA_BYTE_VAL = 8'h00;
  localparam int BIT_POLICY_ON = 7;
  localparam int BIT_CLOCK_STOP = 6;
  localparam int BIT_SOCKET0_VIDEO = 15;
  localparam int BIT_SOCKET1_VIDEO = 14;
  localparam int BIT_SUPPLY_CHANGE = 11;
  localparam int BIT_TWELVE_VOLT = 8;
  localparam int NUM_INPUTS = 5;
  localparam logic [15:0] STATUS_IMPL_MASK = 16'hC91F;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [1:0] PSTATE_D3HOT = 2'h3;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage

// ===== pbe_evt_if.sv
// Carrier for synchronised input levels and their change pulses.
// Assumes one clock domain shared by source and user.
`timescale 1ns/10ps
interface pbe_evt_if;
  logic [pbe_pkg::NUM_INPUTS-1:0] level;
  logic [pbe_pkg::NUM_INPUTS-1:0] change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface

// ===== pbe_input_sync.sv
// Two-stage synchroniser and change detector for general-purpose inputs.
// Assumes raw terminal levels may be asynchronous to clk_i.
`timescale 1ns/10ps
module pbe_input_sync #(
  parameter int WIDTH = pbe_pkg::NUM_INPUTS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] raw_i,
  pbe_evt_if.src evt
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;
  logic [2:0] warm;
  logic [WIDTH-1:0] chg;
  logic [WIDTH-1:0] next_prev;
  logic [2:0] next_warm;
  logic [WIDTH-1:0] next_chg;

  always_comb begin
    next_prev = stable;
    next_warm = {warm[1:0], 1'b1};
    // Stable and prev hold real samples only after three edges
    next_chg = warm[2] ? (stable ^ prev) : '0;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
      warm <= 3'h0;
      chg <= '0;
    end else begin
      meta <= raw_i;
      stable <= meta;
      prev <= next_prev;
      warm <= next_warm;
      chg <= next_chg;
    end
  end

  assign evt.level = stable;
  assign evt.change = chg;
endmodule

// ===== pbe_chk.sv
// Port assertions for the event status block.
// Assumes one clock domain; bound to pbe_top.
`timescale 1ns/10ps
module pbe_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_func_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic [1:0] power_state_field_i,
  input wire logic video_port_enable_bit_f0_i,
  input wire logic [15:0] event_enable_i,
  input wire logic event_route_on_i,
  input wire logic general_event_out_n_o,
  input wire logic general_event_oe_o,
  input wire logic secondary_clock_stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ext;
    cfg_req_i && !cfg_we_i && cfg_addr_i == 8'hA4 |=> cfg_rdata_o == 32'h00C00000;
  endproperty
  a_ext: assert property (p_ext) else $error("bad pm dword");
  property p_rsv;
    cfg_req_i && cfg_addr_i == 8'hA8 |=> (cfg_rdata_o & 32'hFFFF36E0) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_f1;
    cfg_req_i && cfg_func_i && cfg_addr_i == 8'hA8 |=> cfg_rdata_o == 32'h0;
  endproperty
  a_f1: assert property (p_f1) else $error("status seen via function 1");
  property p_v0;
    $changed(video_port_enable_bit_f0_i) && event_enable_i[15] && event_route_on_i
      |-> ##[1:3] !general_event_out_n_o;
  endproperty
  a_v0: assert property (p_v0) else $error("no event on video change");
  property p_oe;
    $past(rstn_i) |-> general_event_oe_o == $past(event_route_on_i);
  endproperty
  a_oe: assert property (p_oe) else $error("oe not following route");
  property p_hold;
    !general_event_out_n_o && event_route_on_i && $stable(event_route_on_i) && $stable(event_enable_i)
      && !cfg_req_i && !$past(cfg_req_i) |=> !general_event_out_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("event dropped early");
  property p_stop;
    $past(rstn_i) |-> secondary_clock_stop_o == ($past(power_state_field_i) == 2'h3);
  endproperty
  a_stop: assert property (p_stop) else $error("clock stop wrong");
  property p_clr;
    cfg_req_i && cfg_we_i && !cfg_func_i && cfg_addr_i == 8'hA8 && cfg_be_i[1:0] == 2'h3
      && cfg_wdata_i[15:0] == 16'hFFFF |-> ##2 general_event_out_n_o;
  endproperty
  a_clr: assert property (p_clr) else $error("event not released");
  c_rd: cover property (cfg_ack_o && cfg_rdata_o[15]);
  c_ev: cover property (!general_event_out_n_o);
  c_stop: cover property (secondary_clock_stop_o);
endmodule
bind pbe_top pbe_chk u_chk (.clk_i, .rstn_i, .cfg_req_i, .cfg_we_i, .cfg_func_i, .cfg_addr_i, .cfg_be_i,
  .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o, .power_state_field_i, .video_port_enable_bit_f0_i,
  .event_enable_i, .event_route_on_i, .general_event_out_n_o, .general_event_oe_o, .secondary_clock_stop_o);

// ===== pbe_src_model.sv
// Socket and terminal side: event sources held as levels.
// Assumes the bench pulses tgl_i for one cycle per change.
`timescale 1ns/10ps
module pbe_src_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [16:0] tgl_i,
  output logic [16:0] src_o
);
  logic [16:0] next_src;
  always_comb next_src = src_o ^ tgl_i;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) src_o <= 17'h00000;
    else src_o <= next_src;
  end
endmodule

// ===== testbench.sv
// Self-checking bench for pbe_top.
// Assumes the source model drives all event inputs.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic fn = 1'b0;
  logic route = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [1:0] ps = 2'h0;
  logic [15:0] en = 16'h0;
  logic [3:0] be = 4'hF;
  logic [16:0] tgl = 17'h0;
  logic [16:0] src, m;
  logic ack, evn, oe, stop, poff;
  logic [31:0] rd;
  logic [31:0] q[$];
  int miscompares = 0;
  int n_checks = 0;
  integer seed = 32'hB925A734;
  initial forever #2.5 clk = ~clk;
  pbe_src_model u_src (.clk_i(clk), .rstn_i(rstn), .tgl_i(tgl), .src_o(src));
  pbe_top dut (.clk_i(clk), .rstn_i(rstn), .cfg_req_i(req), .cfg_we_i(we), .cfg_func_i(fn), .cfg_addr_i(addr),
    .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_ack_o(ack), .cfg_rdata_o(rd), .power_state_field_i(ps),
    .video_port_enable_bit_f0_i(src[16]), .video_port_enable_bit_f1_i(src[15]), .socket0_supply_i(src[14:11]),
    .socket1_supply_i(src[10:7]), .socket0_vpp12_i(src[6]), .socket1_vpp12_i(src[5]),
    .multi_terminal_i(src[4:0]), .event_enable_i(en), .event_route_on_i(route), .general_event_out_n_o(evn),
    .general_event_oe_o(oe), .secondary_clock_stop_o(stop), .secondary_power_off_o(poff));
  function automatic logic [31:0] ex(input logic [16:0] t);
    ex = {16'h0, t[16], t[15], 2'h0, |t[14:7], 2'h0, |t[6:5], 3'h0, t[4:0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input logic w, input logic f, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    fn <= f;
    addr <= a;
    wd <= d;
    q.push_back(e);
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic toggle(input logic [16:0] t);
    @(posedge clk);
    tgl <= t;
    @(posedge clk);
    tgl <= 17'h0;
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (ack === 1'b1) chk(rd, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    cyc(1'b0, 1'b1, 8'hA4, 32'h0, 32'h00C00000);
    cyc(1'b1, 1'b0, 8'hA4, $random(seed), 32'h0);
    cyc(1'b0, 1'b0, 8'hA4, 32'h0, 32'h00C00000);
    cyc(1'b0, 1'b0, 8'hA8, 32'h0, 32'h0);
    for (int i = 0; i < 17; i++) begin
      toggle(17'h1 << i);
      cyc(1'b0, 1'b1, 8'hA8, 32'h0, 32'h0);
      cyc(1'b0, 1'b0, 8'hA8, 32'h0, ex(17'h1 << i));
      cyc(1'b1, 1'b0, 8'hA8, 32'hFFFF, 32'h0);
      cyc(1'b0, 1'b0, 8'hA8, 32'h0, 32'h0);
    end
    en <= 16'hFFFF;
    route <= 1'b1;
    m = 17'($random(seed)) | 17'h10000;
    toggle(m);
    chk({31'h0, evn}, 32'h0);
    chk({31'h0, oe}, 32'h1);
    be <= 4'hC;
    cyc(1'b1, 1'b0, 8'hA8, 32'hFFFF, 32'h0);
    be <= 4'hF;
    cyc(1'b1, 1'b0, 8'hA8, 32'h0, 32'h0);
    cyc(1'b0, 1'b0, 8'hA8, 32'h0, ex(m));
    cyc(1'b1, 1'b0, 8'hA8, 32'hFFFF, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, evn}, 32'h1);
    route <= 1'b0;
    ps <= 2'h3;
    repeat (3) @(posedge clk);
    chk({30'h0, oe, poff}, 32'h0);
    chk({31'h0, stop}, 32'h1);
    toggle(17'h10000);
    cyc(1'b0, 1'b0, 8'hA8, 32'h0, 32'h00008000);
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(1'b0, 1'b0, 8'hA8, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(q.size()), 32'h0);
    summarize();
  end
endmodule
